// file: hw/processor_status_regs.sv
// processor status register bank of one processor tile
`timescale 1ns/1ns
`include "procstat_regs.svh"

// Summary of operation
// - ram base resets to 0x00010000; bits 31:2 writable, 1:0 read zero
// - event target is vector base 31:16 above the 16-bit event vector
// - tile control bit 4, reset zero, enables the clock divider
// - bit 5 picks dynamic mode: divide only while all cores paused
// - boot status: tile number 23:16, otp boot bit 8, mode pins 7:0
// - security register is a read-only copy of the otp security word
// - four free-running ring oscillators each have their rising edges counted on the tile clock
// - oscillator control bit 1 tile, bit 0 peripheral, both reset zero
// - oscillators run asynchronously to the tile clock
// - counter in bits 15:0, upper bits zero, kept through reset
// - counters sit at 0x07..0x0A: tile cell, tile wire, peri cell, wire
// - register 0x10 captures the saved status when debug is entered
// - one-word status reads and writes, decoded by register number
module processor_status_regs #(
    parameter int OSC_CNT_W = `PS_OSC_CNT_W,
    parameter int DIV_RATIO = `PS_CLK_DIV_RATIO
) (
    input wire logic CLK_I,                          // tile clock
    input wire logic SRST_I,                         // sync reset, high
    input wire procstat_pkg::ps_req_s PS_REQ_I,      // status access
    output procstat_pkg::ps_rsp_s PS_RSP_O,          // access answer
    input wire logic EVT_TAKE_I,                     // event taken pulse
    input wire logic [15:0] EVT_VECTOR_I,            // event vector
    output procstat_pkg::vec_tgt_s VEC_TGT_O,        // target address
    output logic [31:0] RAM_BASE_O,                  // ram base address
    input wire logic CORES_PAUSED_I,                 // all cores paused
    output logic CLK_DIV_ACTIVE_O,                   // divider slowing
    output logic TILE_CLK_TICK_O,                    // tile clock enable
    input wire logic [7:0] TILE_NUM_I,               // tile switch number
    input wire logic OTP_BOOT_EN_I,                  // otp boot enabled
    input wire logic [7:0] BOOT_MODE_I,              // boot mode pins
    input wire logic [31:0] SEC_WORD_I,              // otp security word
    input wire logic [3:0] OSC_RAW_I,                // ring osc outputs
    output logic [3:0] OSC_RUN_O,                    // ring osc enables
    input wire logic DBG_ENTER_I,                    // debugger called
    input wire logic [31:0] SAVED_STATUS_REG_I       // current status
);

    // register number carried by a resource identifier
    function automatic procstat_pkg::reg_num_t reg_of(
        input logic [31:0] rid
    );
        reg_of = rid[`PS_RID_REG_LSB +: 8];
    endfunction

    // true when the identifier names the processor status resource
    function automatic logic is_ps(input logic [31:0] rid);
        is_ps = (rid[`PS_RID_TYPE_LSB +: 8] == `PS_RID_TYPE)
            && (rid[31:16] == 16'h0000);
    endfunction

    // widen a counter to a bus word, upper bits zero
    function automatic logic [31:0] cnt_word(
        input logic [OSC_CNT_W-1:0] c
    );
        cnt_word = 32'(c);
    endfunction

    logic [31:0] ram_base_r;
    logic [31:0] ram_base_nxt;
    logic [31:0] vec_base_r;
    logic [31:0] vec_base_nxt;
    logic div_en_r;
    logic div_en_nxt;
    logic div_dyn_r;
    logic div_dyn_nxt;
    logic osc_tile_en_r;
    logic osc_tile_en_nxt;
    logic osc_peri_en_r;
    logic osc_peri_en_nxt;
    logic [31:0] dbg_ssr_r;
    logic [31:0] dbg_ssr_nxt;
    procstat_pkg::ps_rsp_s rsp_r;
    procstat_pkg::ps_rsp_s rsp_nxt;
    procstat_pkg::vec_tgt_s vec_r;
    procstat_pkg::vec_tgt_s vec_nxt;
    logic [3:0] osc_run_r;
    logic [3:0] osc_run_nxt;
    logic div_active;
    logic div_tick;
    logic [OSC_CNT_W-1:0] osc_cnt [4];

    // access decode
    wire procstat_pkg::reg_num_t rnum = reg_of(PS_REQ_I.res_id);
    wire acc = PS_REQ_I.valid & is_ps(PS_REQ_I.res_id);
    wire wr = acc & PS_REQ_I.write;
    wire rd = acc & ~PS_REQ_I.write;
    wire bad = PS_REQ_I.valid & ~is_ps(PS_REQ_I.res_id);

    wire hit_ram = (rnum == `PS_REG_RAM_BASE);
    wire hit_vec = (rnum == `PS_REG_VEC_BASE);
    wire hit_ctrl = (rnum == `PS_REG_TILE_CTRL);
    wire hit_boot = (rnum == `PS_REG_BOOT_STAT);
    wire hit_sec = (rnum == `PS_REG_SEC_CFG);
    wire hit_osc = (rnum == `PS_REG_OSC_CTRL);
    wire hit_tc = (rnum == `PS_REG_OSC_TILE_CELL);
    wire hit_tw = (rnum == `PS_REG_OSC_TILE_WIRE);
    wire hit_pc = (rnum == `PS_REG_OSC_PERI_CELL);
    wire hit_pw = (rnum == `PS_REG_OSC_PERI_WIRE);
    wire hit_ssr = (rnum == `PS_REG_DBG_SSR);
    wire mapped = hit_ram | hit_vec | hit_ctrl | hit_boot | hit_sec
        | hit_osc | hit_tc | hit_tw | hit_pc | hit_pw | hit_ssr;

    // read-only registers take no write and report it as an error
    wire writable = hit_ram | hit_vec | hit_ctrl | hit_osc;
    wire wr_ok = wr & writable;
    wire acc_err = bad | (acc & ~mapped) | (wr & mapped & ~writable);

    // register images as seen on a read
    wire [31:0] ctrl_word = (32'(div_en_r) << `PS_CTRL_DIV_EN_BIT)
        | (32'(div_dyn_r) << `PS_CTRL_DIV_DYN_BIT);
    wire [31:0] boot_word = (32'(TILE_NUM_I) << `PS_BOOT_TILE_LSB)
        | (32'(OTP_BOOT_EN_I) << `PS_BOOT_OTP_BIT)
        | (32'(BOOT_MODE_I) << `PS_BOOT_MODE_LSB);
    wire [31:0] osc_word = (32'(osc_tile_en_r) << `PS_OSC_TILE_EN_BIT)
        | (32'(osc_peri_en_r) << `PS_OSC_PERI_EN_BIT);

    wire [31:0] rd_word =
        hit_ram ? ram_base_r :
        hit_vec ? vec_base_r :
        hit_ctrl ? ctrl_word :
        hit_boot ? boot_word :
        hit_sec ? SEC_WORD_I :
        hit_osc ? osc_word :
        hit_tc ? cnt_word(osc_cnt[0]) :
        hit_tw ? cnt_word(osc_cnt[1]) :
        hit_pc ? cnt_word(osc_cnt[2]) :
        hit_pw ? cnt_word(osc_cnt[3]) :
        hit_ssr ? dbg_ssr_r :
        32'h0000_0000;

    // writable fields
    wire [31:0] wdata = PS_REQ_I.wdata;
    wire wr_ram = wr_ok & hit_ram;
    wire wr_vec = wr_ok & hit_vec;
    wire wr_ctrl = wr_ok & hit_ctrl;
    wire wr_osc = wr_ok & hit_osc;

    assign ram_base_nxt = wr_ram ?
        (wdata & `PS_RAM_BASE_WMASK) : ram_base_r;
    assign vec_base_nxt = wr_vec ?
        (wdata & `PS_VEC_BASE_WMASK) : vec_base_r;
    assign div_en_nxt = wr_ctrl ?
        wdata[`PS_CTRL_DIV_EN_BIT] : div_en_r;
    assign div_dyn_nxt = wr_ctrl ?
        wdata[`PS_CTRL_DIV_DYN_BIT] : div_dyn_r;
    assign osc_tile_en_nxt = wr_osc ?
        wdata[`PS_OSC_TILE_EN_BIT] : osc_tile_en_r;
    assign osc_peri_en_nxt = wr_osc ?
        wdata[`PS_OSC_PERI_EN_BIT] : osc_peri_en_r;

    // tile pair first, then peripheral pair, in counter order
    assign osc_run_nxt = {osc_peri_en_nxt, osc_peri_en_nxt,
        osc_tile_en_nxt, osc_tile_en_nxt};

    // the saved status is captured only on debug entry
    assign dbg_ssr_nxt = DBG_ENTER_I ?
        SAVED_STATUS_REG_I : dbg_ssr_r;

    // answer: one cycle after the access, reads carry data
    assign rsp_nxt.ack = PS_REQ_I.valid;
    assign rsp_nxt.err = acc_err;
    assign rsp_nxt.rdata = (rd & mapped) ? rd_word : 32'h0000_0000;

    // the target uses the base as it stands before a same-cycle write
    assign vec_nxt.valid = EVT_TAKE_I;
    assign vec_nxt.addr = EVT_TAKE_I ?
        {vec_base_r[31:`PS_VEC_SPLIT], EVT_VECTOR_I} :
        vec_r.addr;

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            ram_base_r <= `PS_RAM_BASE_RST;
            vec_base_r <= `PS_VEC_BASE_RST;
            {div_dyn_r, div_en_r} <= `PS_CTRL_RST;
        end else begin
            ram_base_r <= ram_base_nxt;
            vec_base_r <= vec_base_nxt;
            div_en_r <= div_en_nxt;
            div_dyn_r <= div_dyn_nxt;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            {osc_tile_en_r, osc_peri_en_r} <= `PS_OSC_CTRL_RST;
            osc_run_r <= 4'h0;
        end else begin
            osc_tile_en_r <= osc_tile_en_nxt;
            osc_peri_en_r <= osc_peri_en_nxt;
            osc_run_r <= osc_run_nxt;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            dbg_ssr_r <= 32'h0000_0000;
        end else begin
            dbg_ssr_r <= dbg_ssr_nxt;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            rsp_r <= '0;
            vec_r <= '0;
        end else begin
            rsp_r <= rsp_nxt;
            vec_r <= vec_nxt;
        end
    end

    // counters stay outside reset so that the entropy survives it
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_osc
            ring_osc_counter #(
                .CNT_W(OSC_CNT_W)
            ) u_cnt (
                .clk_i(CLK_I),
                .osc_i(OSC_RAW_I[g]),
                .count_o(osc_cnt[g])
            );
        end
    endgenerate

    tile_clock_divider #(
        .RATIO(DIV_RATIO)
    ) u_div (
        .clk_i(CLK_I),
        .srst_i(SRST_I),
        .enable_i(div_en_r),
        .dynamic_i(div_dyn_r),
        .paused_i(CORES_PAUSED_I),
        .active_o(div_active),
        .tick_o(div_tick)
    );

    assign PS_RSP_O = rsp_r;
    assign VEC_TGT_O = vec_r;
    assign RAM_BASE_O = ram_base_r;
    assign OSC_RUN_O = osc_run_r;
    assign CLK_DIV_ACTIVE_O = div_active;
    assign TILE_CLK_TICK_O = div_tick;

endmodule

// file: hw/procstat_pkg.sv
// types shared by the processor status bank
package procstat_pkg;

    // one status access from the core, valid for one cycle
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] res_id;
        logic [31:0] wdata;
    } ps_req_s;

    // answer to an access, one cycle after it
    typedef struct packed {
        logic        ack;
        logic        err;
        logic [31:0] rdata;
    } ps_rsp_s;

    // an event or interrupt target address
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
    } vec_tgt_s;

    typedef logic [7:0] reg_num_t;

endpackage

// file: hw/procstat_regs.svh
// offsets, field positions and reset values of the processor status bank
`ifndef PROCSTAT_REGS_SVH
`define PROCSTAT_REGS_SVH

`define PS_RID_TYPE 8'h0C
`define PS_RID_TYPE_LSB 0
`define PS_RID_REG_LSB 8

`define PS_REG_RAM_BASE 8'h00
`define PS_REG_VEC_BASE 8'h01
`define PS_REG_TILE_CTRL 8'h02
`define PS_REG_BOOT_STAT 8'h03
`define PS_REG_SEC_CFG 8'h05
`define PS_REG_OSC_CTRL 8'h06
`define PS_REG_OSC_TILE_CELL 8'h07
`define PS_REG_OSC_TILE_WIRE 8'h08
`define PS_REG_OSC_PERI_CELL 8'h09
`define PS_REG_OSC_PERI_WIRE 8'h0A
`define PS_REG_DBG_SSR 8'h10

`define PS_RAM_BASE_RST 32'h0001_0000
`define PS_RAM_BASE_WMASK 32'hFFFF_FFFC
`define PS_VEC_BASE_RST 32'h0000_0000
`define PS_VEC_BASE_WMASK 32'hFFFF_0000
`define PS_VEC_SPLIT 16

`define PS_CTRL_DIV_EN_BIT 4
`define PS_CTRL_DIV_DYN_BIT 5
`define PS_CTRL_RST 2'h0

`define PS_BOOT_TILE_LSB 16
`define PS_BOOT_OTP_BIT 8
`define PS_BOOT_MODE_LSB 0

`define PS_OSC_PERI_EN_BIT 0
`define PS_OSC_TILE_EN_BIT 1
`define PS_OSC_CTRL_RST 2'h0

`define PS_OSC_CNT_W 16
`define PS_CLK_DIV_RATIO 4

`endif

// file: hw/ring_osc_counter.sv
// counter, on the tile clock, of the rising edges of one free-running ring oscillator output
`timescale 1ns/1ns
`include "procstat_regs.svh"

module ring_osc_counter #(
    parameter int CNT_W = `PS_OSC_CNT_W
) (
    input wire logic clk_i,              // tile clock
    input wire logic osc_i,              // raw oscillator output
    output logic [CNT_W-1:0] count_o     // running count
);

    // the oscillator is asynchronous to the tile clock
    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    // power-up value only; no system reset ever reaches the count
    logic [CNT_W-1:0] count_r = '0;
    logic [CNT_W-1:0] count_nxt;
    wire rise = sync2_r & ~prev_r;

    assign count_nxt = count_r + CNT_W'(1);
    assign count_o = count_r;

    always_ff @(posedge clk_i) begin
        sync1_r <= osc_i;
        sync2_r <= sync1_r;
        prev_r <= sync2_r;
    end

    // no reset on purpose: the count survives a system reset
    always_ff @(posedge clk_i) begin
        if (rise) begin
            count_r <= count_nxt;
        end
    end

endmodule

// file: hw/tile_clock_divider.sv
// clock divider control for the tile clock, static or dynamic mode
`timescale 1ns/1ns
`include "procstat_regs.svh"

module tile_clock_divider #(
    parameter int RATIO = `PS_CLK_DIV_RATIO
) (
    input wire logic clk_i,       // tile clock
    input wire logic srst_i,      // synchronous reset, active high
    input wire logic enable_i,    // divider enabled
    input wire logic dynamic_i,   // act only while cores paused
    input wire logic paused_i,    // all active cores paused
    output logic active_o,        // divider currently slowing clock
    output logic tick_o           // tile clock enable pulse
);

    logic active_r;
    logic tick_r;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    wire active_nxt = enable_i & (~dynamic_i | paused_i);
    wire wrap = (cnt_r == 8'(RATIO - 1));

    assign cnt_nxt = wrap ? 8'h00 : cnt_r + 8'h01;
    assign active_o = active_r;
    assign tick_o = tick_r;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            active_r <= 1'b0;
            tick_r <= 1'b1;
            cnt_r <= 8'h00;
        end else begin
            active_r <= active_nxt;
            cnt_r <= active_nxt ? cnt_nxt : 8'h00;
            // undivided: every cycle is a tick
            tick_r <= active_nxt ? wrap : 1'b1;
        end
    end

endmodule

// file: verif/core_access_model.sv
// behavioural core issuing status register reads and writes
`timescale 1ns/1ns
module core_access_model (
    input wire logic clk_i,                     // tile clock
    output procstat_pkg::ps_req_s req_o,        // access to the bank
    input wire procstat_pkg::ps_rsp_s rsp_i     // answer from the bank
);
    initial req_o = '0;
    function automatic logic [31:0] rid_of(input logic [7:0] num);
        return {16'h0000, num, 8'h0C};
    endfunction
    // one word per access, held until the answer edge has passed
    task automatic access(input logic wr, input logic [31:0] rid,
        input logic [31:0] wd, output logic [31:0] rd, output logic er);
        @(negedge clk_i);
        req_o = {1'b1, wr, rid, wd};
        @(negedge clk_i);
        rd = rsp_i.rdata;
        er = rsp_i.err | ~rsp_i.ack;
        // released fields carry junk so stale values cannot pass
        req_o = {1'b0, ~wr, ~rid, ~wd};
    endtask
endmodule

// file: verif/processor_status_regs_sva.sv
// port-level checks for the processor status bank
`timescale 1ns/1ns
module processor_status_regs_sva (
    input wire logic CLK_I,                        // tile clock
    input wire logic SRST_I,                       // sync reset
    input wire procstat_pkg::ps_req_s PS_REQ_I,    // access
    input wire procstat_pkg::ps_rsp_s PS_RSP_O,    // answer
    input wire logic EVT_TAKE_I,                   // event taken
    input wire logic [15:0] EVT_VECTOR_I,          // event vector
    input wire procstat_pkg::vec_tgt_s VEC_TGT_O,  // event target
    input wire logic [31:0] RAM_BASE_O,            // ram base
    input wire logic CORES_PAUSED_I,               // cores paused
    input wire logic CLK_DIV_ACTIVE_O,             // divider active
    input wire logic TILE_CLK_TICK_O,              // clock enable
    input wire logic [3:0] OSC_RUN_O               // osc enables
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (SRST_I);
    wire logic acc = PS_REQ_I.valid;
    wire logic wacc = acc && PS_REQ_I.write;
    wire logic ram_wr = wacc && PS_REQ_I.res_id == 32'h0000_000C;
    wire logic ctl_wr = wacc && PS_REQ_I.res_id == 32'h0000_020C;
    wire logic osc_wr = wacc && PS_REQ_I.res_id == 32'h0000_060C;

    ack_each_access_a: assert property (acc |=> PS_RSP_O.ack)
        else $error("access not acknowledged");
    ack_only_access_a: assert property (!acc |=> !PS_RSP_O.ack)
        else $error("acknowledge without access");
    bad_type_err_a: assert property (
        acc && PS_REQ_I.res_id[7:0] != 8'h0C
        |=> PS_RSP_O.err && PS_RSP_O.rdata == 32'h0)
        else $error("wrong resource type not refused");
    ram_reset_a: assert property (
        $fell(SRST_I) |-> RAM_BASE_O == 32'h0001_0000)
        else $error("ram base reset value wrong");
    ram_write_a: assert property (ram_wr |=>
        RAM_BASE_O == ($past(PS_REQ_I.wdata) & 32'hFFFF_FFFC))
        else $error("ram base write not applied");
    ram_low_zero_a: assert property (RAM_BASE_O[1:0] == 2'b00)
        else $error("ram base reserved bits set");
    vec_target_a: assert property (EVT_TAKE_I |=> VEC_TGT_O.valid &&
        VEC_TGT_O.addr[15:0] == $past(EVT_VECTOR_I))
        else $error("event target wrong");
    osc_write_a: assert property (osc_wr |=> OSC_RUN_O ==
        {{2{$past(PS_REQ_I.wdata[0])}}, {2{$past(PS_REQ_I.wdata[1])}}})
        else $error("oscillator enables wrong");
    div_static_a: assert property (
        ctl_wr && PS_REQ_I.wdata[5:4] == 2'b01 |=> ##1 CLK_DIV_ACTIVE_O)
        else $error("static divider not active");
    div_dynamic_a: assert property (ctl_wr &&
        PS_REQ_I.wdata[5:4] == 2'b11 ##1 !CORES_PAUSED_I
        |=> !CLK_DIV_ACTIVE_O)
        else $error("dynamic divider active while running");
    tick_idle_a: assert property (
        !CLK_DIV_ACTIVE_O [*2] |-> TILE_CLK_TICK_O)
        else $error("clock gated while divider idle");

    cover property (wacc);
    cover property (acc ##1 PS_RSP_O.err);
    cover property (EVT_TAKE_I);
    cover property ($rose(CLK_DIV_ACTIVE_O));
endmodule

bind processor_status_regs processor_status_regs_sva chk (
    .CLK_I, .SRST_I, .PS_REQ_I, .PS_RSP_O, .EVT_TAKE_I, .EVT_VECTOR_I,
    .VEC_TGT_O, .RAM_BASE_O, .CORES_PAUSED_I, .CLK_DIV_ACTIVE_O,
    .TILE_CLK_TICK_O, .OSC_RUN_O);

// file: verif/test_processor_status_regs.sv
// self-checking bench for the processor status bank
`timescale 1ns/1ns
module test_processor_status_regs;
    localparam int RATIO = 4;
    logic clk = 1'b0;
    logic srst = 1'b1;
    procstat_pkg::ps_req_s req;
    procstat_pkg::ps_rsp_s rsp;
    procstat_pkg::vec_tgt_s tgt;
    logic evt = 1'b0;
    logic [15:0] evec = 16'h0000;
    logic [31:0] ram;
    logic paused = 1'b0;
    logic div_act;
    logic tick;
    logic [3:0] osc = 4'h0;
    logic [3:0] run;
    logic dbg = 1'b0;
    logic [31:0] saved_status_reg = 32'h0;
    logic [7:0] tnum = 8'h5A;
    logic otp = 1'b1;
    logic [7:0] bmode = 8'hC3;
    logic [31:0] sec = 32'h1357_9BDF;
    logic [31:0] d;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] p;
    logic e;
    int fails = 0;
    int checks = 0;

    processor_status_regs #(.OSC_CNT_W(16), .DIV_RATIO(RATIO)) DUT (
        .CLK_I(clk), .SRST_I(srst), .PS_REQ_I(req), .PS_RSP_O(rsp),
        .EVT_TAKE_I(evt), .EVT_VECTOR_I(evec), .VEC_TGT_O(tgt),
        .RAM_BASE_O(ram), .CORES_PAUSED_I(paused),
        .CLK_DIV_ACTIVE_O(div_act), .TILE_CLK_TICK_O(tick),
        .TILE_NUM_I(tnum), .OTP_BOOT_EN_I(otp), .BOOT_MODE_I(bmode),
        .SEC_WORD_I(sec), .OSC_RAW_I(osc), .OSC_RUN_O(run),
        .DBG_ENTER_I(dbg), .SAVED_STATUS_REG_I(saved_status_reg));
    core_access_model P (.clk_i(clk), .req_o(req), .rsp_i(rsp));

    always #2 clk = ~clk;
    // odd instants never meet a clock edge, like a free ring
    initial begin
        #1;
        forever #6 osc = osc ^ run;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] n, input logic [31:0] exp);
        P.access(1'b0, P.rid_of(n), 32'h0, d, e);
        check(d, exp);
        check({31'h0, e}, 32'h0);
    endtask
    task automatic wr(input logic [7:0] n, input logic [31:0] v);
        P.access(1'b1, P.rid_of(n), v, d, e);
        check({31'h0, e}, 32'h0);
    endtask
    task automatic bad(input logic w, input logic [31:0] rid);
        P.access(w, rid, 32'hFFFF_FFFF, d, e);
        check({31'h0, e}, 32'h1);
        check(d, 32'h0);
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic complete_run;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic t_reset;
        rd(8'h00, 32'h0001_0000);
        rd(8'h02, 32'h0);
        rd(8'h06, 32'h0);
        check({28'h0, run}, 32'h0);
    endtask
    task automatic t_bases;
        wr(8'h00, 32'hFFFF_FFFF);
        rd(8'h00, 32'hFFFF_FFFC);
        check(ram, 32'hFFFF_FFFC);
        wr(8'h01, 32'hABCD_1234);
        rd(8'h01, 32'hABCD_0000);
        @(negedge clk);
        evt = 1'b1;
        evec = 16'h5678;
        @(negedge clk);
        evt = 1'b0;
        check({tgt.valid, tgt.addr}, {1'b1, 32'hABCD_5678});
    endtask
    task automatic t_status;
        rd(8'h03, 32'h005A_01C3);
        rd(8'h05, 32'h1357_9BDF);
        bad(1'b1, P.rid_of(8'h05));
        bad(1'b0, P.rid_of(8'h04));
        bad(1'b0, 32'h0000_010D);
        // status inputs are read live, so new levels show at once
        tnum = 8'hA5;
        otp = 1'b0;
        bmode = 8'h3C;
        sec = 32'hECA8_6420;
        rd(8'h03, 32'h00A5_003C);
        rd(8'h05, 32'hECA8_6420);
        @(negedge clk);
        dbg = 1'b1;
        saved_status_reg = 32'hDEAD_BEEF;
        @(negedge clk);
        dbg = 1'b0;
        saved_status_reg = 32'h0;
        rd(8'h10, 32'hDEAD_BEEF);
    endtask
    task automatic t_div;
        logic [31:0] n;
        wr(8'h02, 32'hFFFF_FFFF);
        rd(8'h02, 32'h0000_0030);
        check({31'h0, div_act}, 32'h0);
        paused = 1'b1;
        cycles(3);
        check({31'h0, div_act}, 32'h1);
        wr(8'h02, 32'h10);
        paused = 1'b0;
        cycles(3);
        check({31'h0, div_act}, 32'h1);
        n = 0;
        repeat (2 * RATIO) begin
            @(negedge clk);
            n = n + 32'(tick);
        end
        check(n, 32'h2);
        wr(8'h02, 32'h0);
        cycles(3);
        check({30'h0, div_act, tick}, 32'h1);
    endtask
    task automatic t_osc;
        P.access(1'b0, P.rid_of(8'h09), 32'h0, p, e);
        wr(8'h06, 32'h2);
        check({28'h0, run}, 32'h3);
        cycles(20);
        wr(8'h06, 32'h0);
        cycles(4);
        P.access(1'b0, P.rid_of(8'h07), 32'h0, a, e);
        check(a & 32'hFFFF_0000, 32'h0);
        wr(8'h06, 32'h2);
        cycles(20);
        wr(8'h06, 32'h0);
        cycles(4);
        P.access(1'b0, P.rid_of(8'h07), 32'h0, b, e);
        check({31'h0, b !== a}, 32'h1);
        rd(8'h09, p);
        wr(8'h06, 32'h1);
        check({28'h0, run}, 32'hC);
        wr(8'h06, 32'h0);
        // a second reset must leave the stopped count alone
        srst = 1'b1;
        cycles(3);
        srst = 1'b0;
        rd(8'h07, b);
        rd(8'h00, 32'h0001_0000);
    endtask

    initial begin
        #20000;
        fails++;
        complete_run();
    end
    initial begin
        cycles(3);
        srst = 1'b0;
        t_reset();
        t_bases();
        t_status();
        t_div();
        t_osc();
        complete_run();
    end
endmodule
